// ==== inc/vrsc_pkg.sv ====
// Shared constants and types for the reference and start-up control core
package vrsc_pkg;
  localparam int REF_W         = 9;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SW_PERIOD_NS  = 4348;
  localparam int SW_CYC        = SW_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W        = $clog2(SW_CYC);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SW_CYC - 1);
  localparam int SAMPLES_FIVE  = 4;
  localparam int SAMPLES_SIX   = 6;
  localparam logic [TICK_W-1:0] SMP_FIVE_LAST = TICK_W'(SW_CYC / SAMPLES_FIVE - 1);
  localparam logic [TICK_W-1:0] SMP_SIX_LAST  = TICK_W'(SW_CYC / SAMPLES_SIX - 1);
  localparam logic [1:0] MATCH_NEED = 2'h3;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] SS_DELAY_LAST = 4'hf;
  localparam logic [CNT_W-1:0] SS_STEP_LAST  = 4'hf;
  localparam logic [CNT_W-1:0] DVID_LAST     = 4'h3;
  localparam int STEP_UV       = 12500;
  localparam int SIX_ANCHOR_UV = 1375000;
  localparam int SIX_ANCHOR_CD = 39;
  localparam logic [REF_W-1:0] SIX_SUM_U = REF_W'(SIX_ANCHOR_UV / STEP_UV + SIX_ANCHOR_CD);
  localparam int FIVE_TOP_UV   = 1850000;
  localparam logic [REF_W-1:0] FIVE_TOP_U  = REF_W'(FIVE_TOP_UV / STEP_UV);
  localparam logic [REF_W-1:0] FIVE_STEP_U = REF_W'(25000 / STEP_UV);
  localparam logic [REF_W-1:0] OVP_MARGIN_U = REF_W'(200000 / STEP_UV);
  localparam logic [REF_W-1:0] OVP_FIX_A_U  = REF_W'(1950000 / STEP_UV);
  localparam logic [REF_W-1:0] OVP_FIX_B_U  = REF_W'(1650000 / STEP_UV);
  localparam logic [REF_W-1:0] OV_HYST_U    = REF_W'(50000 / STEP_UV);
  localparam logic [4:0] NOLOAD_CODE = 5'h1f;
  localparam logic [5:0] CODE_RESET  = 6'h1f;
  localparam int SYNC_W = 11;
  typedef enum logic [1:0] {
    VRSC_MODE_FIVE_A = 2'h0,
    VRSC_MODE_FIVE_B = 2'h1,
    VRSC_MODE_SIX    = 2'h2
  } vrsc_mode_t;
  typedef enum logic [1:0] {
    VRSC_OFF   = 2'h0,
    VRSC_DELAY = 2'h1,
    VRSC_RAMP  = 2'h3,
    VRSC_RUN   = 2'h2
  } vrsc_state_t;
endpackage

// ==== core/vrsc_ident_filter.sv ====
// Identification code sampler and consecutive-match filter
`timescale 1ns/1ns
module vrsc_ident_filter (
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       six_mode_in,
  input  wire logic [5:0] code_in,
  output logic      [5:0] code_out,
  output logic            change_out
);
  logic [vrsc_pkg::TICK_W-1:0] smp_cnt_q, smp_cnt_d;
  logic [5:0] last_q, last_d, acc_q, acc_d, masked;
  logic [1:0] match_q, match_d;
  logic       chg_q, chg_d, samp;

  ////////////////////////////////////////////////////////////////
  always_comb begin
    samp    = (smp_cnt_q == '0);
    masked  = six_mode_in ? code_in : {1'b0, code_in[4:0]};
    smp_cnt_d = smp_cnt_q - 1'b1;
    last_d  = last_q;
    match_d = match_q;
    acc_d   = acc_q;
    chg_d   = 1'b0;
    if (samp) begin
      smp_cnt_d = six_mode_in ? vrsc_pkg::SMP_SIX_LAST : vrsc_pkg::SMP_FIVE_LAST;
      last_d    = masked;
      if (masked != last_q) begin
        match_d = 2'h1;
      end else if (match_q != vrsc_pkg::MATCH_NEED) begin
        match_d = match_q + 1'b1;
      end
      if (match_d == vrsc_pkg::MATCH_NEED && masked != acc_q) begin
        acc_d = masked;
        chg_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      smp_cnt_q <= '0;
      last_q    <= vrsc_pkg::CODE_RESET;
      acc_q     <= vrsc_pkg::CODE_RESET;
      match_q   <= '0;
      chg_q     <= 1'b0;
    end else begin
      smp_cnt_q <= smp_cnt_d;
      last_q    <= last_d;
      acc_q     <= acc_d;
      match_q   <= match_d;
      chg_q     <= chg_d;
    end
  end

  assign code_out   = acc_q;
  assign change_out = chg_q;

  ////////////////////////////////////////////////////////////////
  accept_three_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (acc_q != $past(acc_q)) |-> $past(samp) && $past(masked) == $past(last_q)
      && $past(match_q) >= 2'h2)
    else $error("code accepted without three equal samples");

  sample_space_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (samp && six_mode_in) |=> smp_cnt_q == vrsc_pkg::SMP_SIX_LAST)
    else $error("six-bit sample spacing wrong");
endmodule

// ==== core/vrsc_core.sv ====
// Reference, start-up, soft-start and over-voltage control core
// Notes on behaviour
// - Six-bit code maps down-count to 12.5 mV up
// - Five-bit modes use only low five pins
// - Five-bit: four samples, accept after three matches
// - Five-bit: one 25 mV step per four cycles
// - Six-bit: six samples, three matches, jump directly
// - Low-side drives tristated below bias reset level
// - Fixed over-voltage threshold by mode, clamp low-side
// - Soft-start threshold max of fixed, reference+200mV
// - Clamp releases below hysteresis, never latches
// - Switches off while either supply below reset
// - All-ones five-bit code keeps controller disabled
// - Start soft-start once all enables hold
// - Wait 16 cycles, then 12.5 mV per 16
// - Hold switches off while sense above ramp
// - Enable drives at soft-start end regardless
`timescale 1ns/1ns
module vrsc_core (
  input  wire logic                       ref_clk_in,
  input  wire logic                       nrst_in,
  input  wire logic                       ident_bit0_in,
  input  wire logic                       ident_bit1_in,
  input  wire logic                       ident_bit2_in,
  input  wire logic                       ident_bit3_in,
  input  wire logic                       ident_bit4_in,
  input  wire logic                       ident_bit5_in,
  input  wire logic [1:0]                 mode_sel_in,
  input  wire logic                       bias_por_ok_in,
  input  wire logic                       driver_supply_ok_in,
  input  wire logic                       threshold_enable_input_in,
  input  wire logic [vrsc_pkg::REF_W-1:0] feedback_sense_in,
  output logic      [vrsc_pkg::REF_W-1:0] reference_setpoint_out,
  output logic      [vrsc_pkg::REF_W-1:0] ov_threshold_out,
  output logic                            overvoltage_clamp_out,
  output logic      [1:0]                 low_side_gate_out,
  output logic      [1:0]                 low_side_gate_oe_out,
  output logic                            pwm_enable_out,
  output logic                            soft_start_out
);
  localparam int RW = vrsc_pkg::REF_W;

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [vrsc_pkg::SYNC_W-1:0] pin_raw, s1_q, s2_q, s3_q, pin_q, pin_d;

  assign pin_raw = {mode_sel_in, threshold_enable_input_in, driver_supply_ok_in, bias_por_ok_in,
                    ident_bit5_in, ident_bit4_in, ident_bit3_in, ident_bit2_in, ident_bit1_in,
                    ident_bit0_in};

  genvar g;
  for (g = 0; g < vrsc_pkg::SYNC_W; g++) begin : g_sync
    assign pin_d[g] = (s2_q[g] == s3_q[g]) ? s2_q[g] : pin_q[g];
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      pin_q <= '0;
    end else begin
      s1_q  <= pin_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= pin_d;
    end
  end

  logic                 bias_ok, drv_ok, en_ok, six, go, chg;
  logic [5:0]           code;
  vrsc_pkg::vrsc_mode_t mode;

  assign bias_ok = pin_q[6];
  assign drv_ok  = pin_q[7];
  assign en_ok   = pin_q[8];
  assign mode    = vrsc_pkg::vrsc_mode_t'(pin_q[10:9]);
  assign six     = (mode == vrsc_pkg::VRSC_MODE_SIX);

  ////////////////////////////////////////////////////////////////
  // Code filter
  vrsc_ident_filter u_filter (
    .ref_clk_in  (ref_clk_in),
    .nrst_in     (nrst_in),
    .six_mode_in (six),
    .code_in     (pin_q[5:0]),
    .code_out    (code),
    .change_out  (chg)
  );

  logic [RW-1:0] target;

  always_comb begin
    if (six) begin
      target = vrsc_pkg::SIX_SUM_U - RW'({code[4:0], code[5]});
    end else begin
      target = vrsc_pkg::FIVE_TOP_U - RW'(RW'(code[4:0]) * vrsc_pkg::FIVE_STEP_U);
    end
  end

  assign go = bias_ok && drv_ok && en_ok && (code[4:0] != vrsc_pkg::NOLOAD_CODE);

  ////////////////////////////////////////////////////////////////
  // Switching-cycle tick
  logic [vrsc_pkg::TICK_W-1:0] tick_q, tick_d;
  logic                        tick;

  always_comb begin
    tick   = (tick_q == '0);
    tick_d = tick ? vrsc_pkg::TICK_LAST : tick_q - 1'b1;
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Start-up sequencer and reference
  vrsc_pkg::vrsc_state_t       state_q, state_d;
  logic [RW-1:0]               ref_q, ref_d;
  logic [vrsc_pkg::CNT_W-1:0]  cnt_q, cnt_d;
  logic                        drive_q, drive_d;

  always_comb begin
    state_d = state_q;
    ref_d   = ref_q;
    cnt_d   = cnt_q;
    drive_d = drive_q;
    if (!go) begin
      state_d = vrsc_pkg::VRSC_OFF;
      ref_d   = '0;
      cnt_d   = '0;
      drive_d = 1'b0;
    end else begin
      case (state_q)
        vrsc_pkg::VRSC_OFF: begin
          state_d = vrsc_pkg::VRSC_DELAY;
          cnt_d   = '0;
        end
        vrsc_pkg::VRSC_DELAY: begin
          if (tick) begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == vrsc_pkg::SS_DELAY_LAST) begin
              state_d = vrsc_pkg::VRSC_RAMP;
              cnt_d   = '0;
            end
          end
        end
        vrsc_pkg::VRSC_RAMP: begin
          if (ref_q > feedback_sense_in) begin
            drive_d = 1'b1;
          end
          if (tick) begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == vrsc_pkg::SS_STEP_LAST) begin
              cnt_d = '0;
              if (ref_q >= target) begin
                state_d = vrsc_pkg::VRSC_RUN;
                ref_d   = target;
                drive_d = 1'b1;
              end else begin
                ref_d = ref_q + 1'b1;
              end
            end
          end
        end
        vrsc_pkg::VRSC_RUN: begin
          drive_d = 1'b1;
          if (six) begin
            ref_d = target;
          end else if (chg) begin
            cnt_d = '0;
          end else if (tick) begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q >= vrsc_pkg::DVID_LAST) begin
              cnt_d = '0;
              if (ref_q + vrsc_pkg::FIVE_STEP_U <= target) begin
                ref_d = ref_q + vrsc_pkg::FIVE_STEP_U;
              end else if (ref_q >= target + vrsc_pkg::FIVE_STEP_U) begin
                ref_d = ref_q - vrsc_pkg::FIVE_STEP_U;
              end else begin
                ref_d = target;
              end
            end
          end
        end
        default: begin
          state_d = vrsc_pkg::VRSC_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= vrsc_pkg::VRSC_OFF;
      ref_q   <= '0;
      cnt_q   <= '0;
      drive_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ref_q   <= ref_d;
      cnt_q   <= cnt_d;
      drive_q <= drive_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Over-voltage threshold, clamp and gate outputs
  logic [RW-1:0] thr_q, thr_d, ref_m, fixed;
  logic          clamp_q, clamp_d, pwm_q, pwm_d, ss_q, ss_d;
  logic [1:0]    gate_q, gate_d, oe_q, oe_d;
  logic          ss_active;

  always_comb begin
    ss_active = (state_d == vrsc_pkg::VRSC_DELAY) || (state_d == vrsc_pkg::VRSC_RAMP);
    ref_m     = ref_d + vrsc_pkg::OVP_MARGIN_U;
    fixed     = (mode == vrsc_pkg::VRSC_MODE_FIVE_A) ? vrsc_pkg::OVP_FIX_A_U : vrsc_pkg::OVP_FIX_B_U;
    if (ss_active) begin
      thr_d = (ref_m > fixed) ? ref_m : fixed;
    end else if (state_d == vrsc_pkg::VRSC_RUN) begin
      thr_d = ref_m;
    end else begin
      thr_d = fixed;
    end
    clamp_d = clamp_q;
    if (!bias_ok) begin
      clamp_d = 1'b0;
    end else if (feedback_sense_in > thr_q) begin
      clamp_d = 1'b1;
    end else if ((RW+1)'(feedback_sense_in) + (RW+1)'(vrsc_pkg::OV_HYST_U) < (RW+1)'(thr_q)) begin
      clamp_d = 1'b0;
    end
    gate_d = {2{clamp_d && bias_ok && drv_ok}};
    oe_d   = {2{bias_ok}};
    pwm_d  = go && drive_d && !clamp_d;
    ss_d   = ss_active;
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      thr_q   <= '0;
      clamp_q <= 1'b0;
      gate_q  <= '0;
      oe_q    <= '0;
      pwm_q   <= 1'b0;
      ss_q    <= 1'b0;
    end else begin
      thr_q   <= thr_d;
      clamp_q <= clamp_d;
      gate_q  <= gate_d;
      oe_q    <= oe_d;
      pwm_q   <= pwm_d;
      ss_q    <= ss_d;
    end
  end

  assign reference_setpoint_out = ref_q;
  assign ov_threshold_out       = thr_q;
  assign overvoltage_clamp_out  = clamp_q;
  assign low_side_gate_out      = gate_q;
  assign low_side_gate_oe_out   = oe_q;
  assign pwm_enable_out         = pwm_q;
  assign soft_start_out         = ss_q;

  ////////////////////////////////////////////////////////////////
  // Checks
  por_off_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (!bias_ok || !drv_ok) |=> !pwm_q && gate_q == 2'h0)
    else $error("switches active below supply reset");

  pre_por_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    !bias_ok |=> oe_q == 2'h0)
    else $error("low-side drive not tristated");

  noload_idle_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (code[4:0] == vrsc_pkg::NOLOAD_CODE) |=> state_q == vrsc_pkg::VRSC_OFF && !pwm_q)
    else $error("running on no-load code");

  start_go_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (state_q == vrsc_pkg::VRSC_OFF && go) |=> state_q == vrsc_pkg::VRSC_DELAY)
    else $error("soft-start not begun");

  ramp_hold_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (go && state_q == vrsc_pkg::VRSC_RAMP && !(tick && cnt_q == vrsc_pkg::SS_STEP_LAST))
      |=> ref_q == $past(ref_q))
    else $error("ramp stepped off schedule");

  six_direct_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (go && six && state_q == vrsc_pkg::VRSC_RUN) |=> ref_q == $past(target))
    else $error("six-bit reference not direct");

  five_step_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (go && !six && state_q == vrsc_pkg::VRSC_RUN && !(tick && cnt_q >= vrsc_pkg::DVID_LAST))
      |=> ref_q == $past(ref_q))
    else $error("five-bit step off schedule");

  ov_trip_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (bias_ok && drv_ok && feedback_sense_in > thr_q) |=> clamp_q && gate_q == 2'h3 && !pwm_q)
    else $error("over-voltage not clamped");

  ov_thr_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (state_q == vrsc_pkg::VRSC_RUN) |-> thr_q == ref_q + vrsc_pkg::OVP_MARGIN_U)
    else $error("run threshold wrong");

  precharge_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (state_q == vrsc_pkg::VRSC_RAMP && !drive_q) |-> !pwm_q)
    else $error("drives on above precharge");

  ss_end_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (go && state_q == vrsc_pkg::VRSC_RAMP && tick && cnt_q == vrsc_pkg::SS_STEP_LAST && ref_q >= target)
      |=> drive_q && state_q == vrsc_pkg::VRSC_RUN)
    else $error("drives not enabled at ramp end");
endmodule

// ==== test/vrsc_load_model.sv ====
// Processor load model driving the identification pins
`timescale 1ns/1ns
module vrsc_load_model #(
  parameter int HOLD_CYC = 300
) (
  input  wire logic ref_clk_in,
  output logic      ident_bit0_out,
  output logic      ident_bit1_out,
  output logic      ident_bit2_out,
  output logic      ident_bit3_out,
  output logic      ident_bit4_out,
  output logic      ident_bit5_out
);
  logic [5:0] pins_q;
  initial pins_q = 6'h1f;
  assign {ident_bit5_out, ident_bit4_out, ident_bit3_out} = pins_q[5:3];
  assign {ident_bit2_out, ident_bit1_out, ident_bit0_out} = pins_q[2:0];
  ////////////////////////////////////////////////////////////////////////////
  // Pin vector to six-bit count order and back
  function automatic logic [5:0] to_cnt(input logic [5:0] p);
    return {p[4:0], p[5]};
  endfunction
  function automatic logic [5:0] to_pins(input logic [5:0] c);
    return {c[0], c[5:1]};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // New request; six-bit requests walk one count at a time
  task automatic drive(input logic [5:0] pins, input logic six);
    logic [5:0] c;
    c = to_cnt(pins_q);
    @(negedge ref_clk_in);
    if (!six) begin
      pins_q = pins;
    end else begin
      while (c != to_cnt(pins)) begin
        c = (c < to_cnt(pins)) ? c + 6'h01 : c - 6'h01;
        pins_q = to_pins(c);
        repeat (HOLD_CYC) @(negedge ref_clk_in);
      end
    end
  endtask
endmodule

// ==== test/test_vrsc_core.sv ====
// Self-checking bench for the reference and start-up control core
`timescale 1ns/1ns
module test_vrsc_core;
  logic                       ref_clk_in;
  logic                       nrst_in;
  logic [1:0]                 mode_sel;
  logic                       bias_ok;
  logic                       drv_ok;
  logic                       en;
  logic [vrsc_pkg::REF_W-1:0] fb;
  logic [5:0]                 pins;
  logic [vrsc_pkg::REF_W-1:0] ref_v;
  logic [vrsc_pkg::REF_W-1:0] thr;
  logic                       clamp;
  logic [1:0]                 gate;
  logic [1:0]                 gate_oe;
  logic                       pwm;
  logic                       ss;
  int                         miscompares;
  int                         comparisons;
  int                         cycles;
  localparam int TICK = vrsc_pkg::SW_CYC;
  ////////////////////////////////////////////////////////////////////////////
  vrsc_load_model lm (
    .ref_clk_in     (ref_clk_in),
    .ident_bit0_out (pins[0]),
    .ident_bit1_out (pins[1]),
    .ident_bit2_out (pins[2]),
    .ident_bit3_out (pins[3]),
    .ident_bit4_out (pins[4]),
    .ident_bit5_out (pins[5])
  );
  vrsc_core uut (
    .ref_clk_in                (ref_clk_in),
    .nrst_in                   (nrst_in),
    .ident_bit0_in             (pins[0]),
    .ident_bit1_in             (pins[1]),
    .ident_bit2_in             (pins[2]),
    .ident_bit3_in             (pins[3]),
    .ident_bit4_in             (pins[4]),
    .ident_bit5_in             (pins[5]),
    .mode_sel_in               (mode_sel),
    .bias_por_ok_in            (bias_ok),
    .driver_supply_ok_in       (drv_ok),
    .threshold_enable_input_in (en),
    .feedback_sense_in         (fb),
    .reference_setpoint_out    (ref_v),
    .ov_threshold_out          (thr),
    .overvoltage_clamp_out     (clamp),
    .low_side_gate_out         (gate),
    .low_side_gate_oe_out      (gate_oe),
    .pwm_enable_out            (pwm),
    .soft_start_out            (ss)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Clock, timeout and shared helpers
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares = miscompares + 1;
      wrap_up();
    end
  end
  task automatic check_val(input logic [15:0] seen, input logic [15:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task automatic wait_for(input logic sel, input logic [8:0] v, input int lim, output int n);
    n = 0;
    while ((sel ? {8'h00, ss} : ref_v) !== v && n < lim) begin
      @(negedge ref_clk_in);
      n++;
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    check_val({gate_oe, gate, pwm, ss, clamp}, 16'h0000);
    check_val(ref_v, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_noload();
    logic [8:0] fix [4];
    fix = '{9'h09c, 9'h084, 9'h084, 9'h084};
    lm.drive(6'h3f, 1'b0);
    for (int m = 0; m < 4; m++) begin
      mode_sel = 2'(m);
      idle(400);
      check_val(thr, fix[m]);
      check_val({pwm, ss}, 16'h0000);
    end
    mode_sel = 2'h0;
    $display("test noload done");
  endtask
  task automatic t_clamp();
    fb = 9'h09d;
    idle(6);
    check_val({clamp, gate, gate_oe, pwm}, 16'h003e);
    fb = 9'h099;
    idle(6);
    check_val(clamp, 16'h0001);
    fb = 9'h097;
    idle(6);
    check_val({clamp, gate}, 16'h0000);
    fb = 9'h09d;
    idle(6);
    check_val({clamp, gate}, 16'h0007);
    bias_ok = 1'b0;
    idle(6);
    check_val({gate, gate_oe}, 16'h0000);
    fb = 9'h000;
    bias_ok = 1'b1;
    idle(6);
    check_val(clamp, 16'h0000);
    $display("test clamp done");
  endtask
  task automatic t_start();
    int n;
    mode_sel = 2'h1;
    en = 1'b0;
    fb = 9'h001;
    lm.drive(6'h30, 1'b0);
    idle(450);
    check_val(ss, 16'h0000);
    en = 1'b1;
    wait_for(1'b1, 9'h001, 20, n);
    check_val(ss, 16'h0001);
    check_val(thr, 16'h0084);
    wait_for(1'b0, 9'h001, 33 * TICK, n);
    check_val(16'(n >= 31 * TICK && n <= 32 * TICK + 8), 16'h0001);
    idle(3);
    check_val(pwm, 16'h0000);
    wait_for(1'b0, 9'h002, 17 * TICK, n);
    check_val(16'(n + 3), 16'(16 * TICK));
    idle(3);
    check_val({pwm, ss}, 16'h0003);
    check_val(thr, 16'h0084);
    $display("test start done");
  endtask
  task automatic t_supply();
    int n;
    drv_ok = 1'b0;
    idle(8);
    check_val({pwm, ss}, 16'h0000);
    check_val(ref_v, 16'h0000);
    drv_ok = 1'b1;
    idle(8);
    check_val(ss, 16'h0001);
    lm.drive(6'h1f, 1'b0);
    wait_for(1'b1, 9'h000, 450, n);
    check_val({pwm, ss}, 16'h0000);
    lm.drive(6'h30, 1'b0);
    idle(150);
    lm.drive(6'h1f, 1'b0);
    wait_for(1'b1, 9'h001, 600, n);
    check_val(16'(n), 16'(600));
    $display("test supply done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    miscompares = 0;
    comparisons = 0;
    cycles = 0;
    nrst_in = 1'b0;
    mode_sel = 2'h0;
    bias_ok = 1'b1;
    drv_ok = 1'b1;
    en = 1'b1;
    fb = 9'h000;
    repeat (8) @(negedge ref_clk_in);
    t_reset();
    nrst_in = 1'b1;
    t_noload();
    t_clamp();
    t_start();
    t_supply();
    wrap_up();
  end
endmodule
